// file: rcs_top.sv
// Reset cause flags and start-up timeout sequencer
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "rcs_params.svh"

module rcs_top
#(
   // Power-up timer in clock cycles; shorten for simulation
   parameter int POWERUP_TIMER_CYCLES = `RCS_POWERUP_TIMER_US * `RCS_CLK_MHZ,
   // Oscillator start-up periods, one per clock
   parameter int OST_CYCLES  = `RCS_OST_PERIODS
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        external_clear_n,
   input  wire logic        brownout_detect,
   input  wire logic [1:0]  brownout_enable_cfg,
   input  wire logic        powerup_timer_enable_n,
   input  wire logic        crystal_osc_modes,
   input  wire logic        watchdog_expire,
   input  wire logic        wake_reset_event,
   input  wire logic        watchdog_clear_instr,
   input  wire logic        sleep_enter,
   output logic             core_run,
   output logic             watchdog_counter_clear,
   output logic             asleep,
   output logic             ultra_low_wake_enable,
   output logic             soft_brownout_enable
);

   // ------------------------------------------------------------------
   // Derived counts, cut to the counter width
   // ------------------------------------------------------------------
   localparam logic [20:0] POWERUP_TIMER_LAST = 21'(POWERUP_TIMER_CYCLES - 1);
   localparam logic [20:0] OST_LAST  = 21'(OST_CYCLES - 1);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   rcs_pkg::rcs_core_s core_reg;    // Registered core state
   rcs_pkg::rcs_core_s core_next;   // Next core state
   logic [1:0]         pin_sync;    // Synced clear and brown-out pins
   logic               clr_n_s;     // Synced external clear level
   logic               bod_s;       // Synced brown-out level
   logic               bor_armed;   // Brown-out circuit enabled
   logic               bor_event;   // Brown-out reset starts
   logic               clr_event;   // External clear falls
   logic [7:0]         power_control_flags_rd;     // Power control read image
   logic [7:0]         stat_rd;     // Core status read image
   logic               power_control_flags_wr;     // Software write pulse
   logic [7:0]         power_control_flags_wdata;  // Software write byte

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // Both pins come from outside the clock domain
   rcs_sync
   #(
      .W       (2),
      .RST_VAL (2'b01)
   )
   u_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({brownout_detect, external_clear_n}),
      .q       (pin_sync)
   );

   assign clr_n_s = pin_sync[0];
   assign bod_s   = pin_sync[1];

   // ------------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------------
   rcs_axil u_axil
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .power_control_flags_rd       (power_control_flags_rd),
      .stat_rd       (stat_rd),
      .power_control_flags_wr       (power_control_flags_wr),
      .power_control_flags_wdata    (power_control_flags_wdata)
   );

   // ------------------------------------------------------------------
   // Read images; unimplemented bits read zero
   // ------------------------------------------------------------------
   always_comb
   begin
      power_control_flags_rd                 = 8'h00;
      power_control_flags_rd[`RCS_BOR_BIT]   = core_reg.bor_n;
      power_control_flags_rd[`RCS_POR_BIT]   = core_reg.por_n;
      power_control_flags_rd[`RCS_WUR_BIT]   = core_reg.wur_n;
      power_control_flags_rd[`RCS_SBOR_BIT]  = core_reg.sbor;
      power_control_flags_rd[`RCS_ULPW_BIT]  = core_reg.ulpw;
      stat_rd                 = 8'h00;
      stat_rd[`RCS_PD_BIT]    = core_reg.pd_n;
      stat_rd[`RCS_TO_BIT]    = core_reg.to_n;
   end

   // ------------------------------------------------------------------
   // Event detection on the synced pins
   // ------------------------------------------------------------------
   // With the circuit disabled the flag is left alone entirely
   assign bor_armed = (brownout_enable_cfg != 2'b00);
   assign bor_event = bor_armed && bod_s && !core_reg.bod_d;
   assign clr_event = !clr_n_s && core_reg.clr_d;

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   // Order inside: software write, watchdog clear, then hardware
   // events, so a hardware event in the same cycle wins
   always_comb
   begin
      core_next         = core_reg;
      core_next.clr_d   = clr_n_s;
      core_next.bod_d   = bod_s;
      core_next.wdt_clr = 1'b0;

      // Software writes the writable flag bits
      if (power_control_flags_wr)
      begin
         core_next.bor_n = power_control_flags_wdata[`RCS_BOR_BIT];
         core_next.por_n = power_control_flags_wdata[`RCS_POR_BIT];
         core_next.wur_n = power_control_flags_wdata[`RCS_WUR_BIT];
         core_next.sbor  = power_control_flags_wdata[`RCS_SBOR_BIT];
         core_next.ulpw  = power_control_flags_wdata[`RCS_ULPW_BIT];
      end

      // Watchdog clear instruction
      if (watchdog_clear_instr)
      begin
         core_next.wdt_clr = 1'b1;
         core_next.to_n    = 1'b1;
         core_next.pd_n    = 1'b1;
      end

      case (core_reg.state)
         // Power-up timer, counted from the power-on pulse
         rcs_pkg::RCS_ST_POWERUP_TIMER:
         begin
            if (!powerup_timer_enable_n && core_reg.cnt != POWERUP_TIMER_LAST)
            begin
               core_next.cnt = core_reg.cnt + 21'h00_0001;
            end
            else if (crystal_osc_modes)
            begin
               core_next.state = rcs_pkg::RCS_ST_OST;
               core_next.cnt   = 21'h00_0000;
            end
            else
            begin
               core_next.state = rcs_pkg::RCS_ST_RUN;
            end
         end

         // Oscillator start-up count
         rcs_pkg::RCS_ST_OST:
         begin
            if (core_reg.cnt != OST_LAST)
            begin
               core_next.cnt = core_reg.cnt + 21'h00_0001;
            end
            else
            begin
               core_next.state = rcs_pkg::RCS_ST_RUN;
            end
         end

         // Normal operation
         rcs_pkg::RCS_ST_RUN:
         begin
            if (watchdog_expire)
            begin
               core_next.to_n = 1'b0;
               core_next.ulpw = 1'b0;
            end
            else if (clr_event)
            begin
               core_next.ulpw = 1'b0;
            end
            else if (sleep_enter)
            begin
               core_next.state = rcs_pkg::RCS_ST_SLEEP;
               core_next.to_n  = 1'b1;
               core_next.pd_n  = 1'b0;
            end
         end

         // Asleep: wait for a wake source
         rcs_pkg::RCS_ST_SLEEP:
         begin
            if (watchdog_expire)
            begin
               core_next.to_n = 1'b0;
               core_next.pd_n = 1'b0;
            end
            else if (wake_reset_event)
            begin
               core_next.wur_n = 1'b0;
               core_next.pd_n  = 1'b0;
               core_next.to_n  = 1'b1;
            end
            else if (clr_event)
            begin
               core_next.to_n = 1'b1;
               core_next.pd_n = 1'b0;
            end
            // Wake: crystal waits the start-up count, others run
            if (watchdog_expire || wake_reset_event || clr_event)
            begin
               core_next.cnt = 21'h00_0000;
               if (crystal_osc_modes)
               begin
                  core_next.state = rcs_pkg::RCS_ST_OST;
               end
               else
               begin
                  core_next.state = rcs_pkg::RCS_ST_RUN;
               end
            end
         end

         default:
         begin
            core_next.state = rcs_pkg::RCS_ST_POWERUP_TIMER;
            core_next.cnt   = 21'h00_0000;
         end
      endcase

      // Brown-out outranks every other source, asleep or not
      if (bor_event)
      begin
         core_next.bor_n = 1'b0;
         core_next.to_n  = 1'b1;
         core_next.pd_n  = 1'b1;
      end
      // Timer stays cleared while the supply is still low
      if (bor_armed && bod_s)
      begin
         core_next.state = rcs_pkg::RCS_ST_POWERUP_TIMER;
         core_next.cnt   = 21'h00_0000;
      end

      // Execution needs the timers done and the clear pin released;
      // a watchdog reset drops it for one cycle
      core_next.run = (core_next.state == rcs_pkg::RCS_ST_RUN)
                      && clr_n_s
                      && !(watchdog_expire
                           && core_reg.state == rcs_pkg::RCS_ST_RUN);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // Only the power-on pulse resets the flags; other resets are
   // events handled above and cannot disturb preserved bits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_reg.state   <= rcs_pkg::RCS_ST_POWERUP_TIMER;
         core_reg.cnt     <= 21'h00_0000;
         core_reg.por_n   <= `RCS_POR_RST;
         core_reg.bor_n   <= `RCS_BOR_RST;
         core_reg.wur_n   <= `RCS_WUR_RST;
         core_reg.to_n    <= `RCS_TO_RST;
         core_reg.pd_n    <= `RCS_PD_RST;
         core_reg.ulpw    <= `RCS_ULPW_RST;
         core_reg.sbor    <= `RCS_SBOR_RST;
         core_reg.clr_d   <= 1'b1;
         core_reg.bod_d   <= 1'b0;
         core_reg.run     <= 1'b0;
         core_reg.wdt_clr <= 1'b0;
      end
      else
      begin
         core_reg <= core_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs from flip-flops; asleep is decoded from the state register
   // ------------------------------------------------------------------
   assign core_run               = core_reg.run;
   assign watchdog_counter_clear = core_reg.wdt_clr;
   assign asleep                 = (core_reg.state == rcs_pkg::RCS_ST_SLEEP);
   assign ultra_low_wake_enable  = core_reg.ulpw;
   assign soft_brownout_enable   = core_reg.sbor;

endmodule

// file: rcs_params.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses (index times four)
// ----------------------------------------------------------------------
`define RCS_POWER_CONTROL_FLAGS_IDX     12'h08e
`define RCS_STAT_IDX     12'h08f
`define RCS_POWER_CONTROL_FLAGS_ADDR    12'h238
`define RCS_STAT_ADDR    12'h23c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RCS_BOR_BIT      0
`define RCS_POR_BIT      1
`define RCS_WUR_BIT      3
`define RCS_SBOR_BIT     4
`define RCS_ULPW_BIT     5
`define RCS_PD_BIT       3
`define RCS_TO_BIT       4

// ----------------------------------------------------------------------
// Reset values of the flags after a power-on pulse
// ----------------------------------------------------------------------
`define RCS_POR_RST      1'b0
`define RCS_BOR_RST      1'b0
`define RCS_WUR_RST      1'b1
`define RCS_TO_RST       1'b1
`define RCS_PD_RST       1'b1
`define RCS_ULPW_RST     1'b0
`define RCS_SBOR_RST     1'b1

// ----------------------------------------------------------------------
// Timing: clock rate, power-up delay, oscillator start-up periods
// ----------------------------------------------------------------------
`define RCS_CLK_MHZ      20
`define RCS_POWERUP_TIMER_US      64000
`define RCS_OST_PERIODS  1024
`define RCS_CNT_W        21

`endif

// file: rcs_pkg.sv
// Types shared by the reset cause block
package rcs_pkg;

   // ------------------------------------------------------------------
   // Start-up sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      RCS_ST_POWERUP_TIMER,
      RCS_ST_OST,
      RCS_ST_RUN,
      RCS_ST_SLEEP
   } rcs_state_e;

   // ------------------------------------------------------------------
   // Whole state of the core
   // ------------------------------------------------------------------
   typedef struct packed
   {
      rcs_state_e           state;     // Sequencer state
      logic [20:0]          cnt;       // Start-up timer count
      logic                 por_n;     // Power-on flag
      logic                 bor_n;     // Brown-out flag
      logic                 wur_n;     // Wake-up reset flag
      logic                 to_n;      // Timeout flag
      logic                 pd_n;      // Power-down flag
      logic                 ulpw;      // Ultra-low-power wake enable
      logic                 sbor;      // Soft brown-out enable
      logic                 clr_d;     // Last synced clear pin level
      logic                 bod_d;     // Last synced brown-out level
      logic                 run;       // Core may execute
      logic                 wdt_clr;   // Watchdog clear pulse
   } rcs_core_s;

endpackage

// file: rcs_sync.sv
// Two flip-flop synchroniser for pin inputs
module rcs_sync
#(
   parameter int          W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // ------------------------------------------------------------------
   // State: first stage feeds the second stage only
   // ------------------------------------------------------------------
   typedef struct packed
   {
      logic [W-1:0] s1;   // Metastable stage
      logic [W-1:0] s2;   // Settled stage
   } rcs_sync_s;

   rcs_sync_s sync_reg;   // Registered state
   rcs_sync_s sync_next;  // Next state

   // Shift the pin through both stages
   always_comb
   begin
      sync_next    = sync_reg;
      sync_next.s1 = d;
      sync_next.s2 = sync_reg.s1;
   end

   // Register with constant reset values
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_reg <= {RST_VAL, RST_VAL};
      end
      else
      begin
         sync_reg <= sync_next;
      end
   end

   assign q = sync_reg.s2;

endmodule

// file: rcs_axil.sv
// AXI4-Lite slave front end for the two flag registers
`include "rcs_params.svh"

module rcs_axil
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  power_control_flags_rd,
   input  wire logic [7:0]  stat_rd,
   output logic             power_control_flags_wr,
   output logic [7:0]       power_control_flags_wdata
);

   // ------------------------------------------------------------------
   // Slave state
   // ------------------------------------------------------------------
   typedef struct packed
   {
      logic        aw_got;   // Write address held
      logic [11:0] aw_addr;  // Held write address
      logic        w_got;    // Write data held
      logic [7:0]  w_data;   // Held low byte
      logic        w_strb0;  // Held low strobe
      logic        bvalid;   // Write answer pending
      logic [1:0]  bresp;    // Write answer code
      logic        rvalid;   // Read answer pending
      logic [31:0] rdata;    // Read data
      logic [1:0]  rresp;    // Read answer code
      logic        wr;       // Register write pulse
   } rcs_axil_s;

   rcs_axil_s ax_reg;   // Registered state
   rcs_axil_s ax_next;  // Next state

   // Accept address and data in either order, one write at a time
   always_comb
   begin
      ax_next    = ax_reg;
      ax_next.wr = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         ax_next.aw_got  = 1'b1;
         ax_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         ax_next.w_got   = 1'b1;
         ax_next.w_data  = s_axi_wdata[7:0];
         ax_next.w_strb0 = s_axi_wstrb[0];
      end
      // Both halves held: answer, and write only a mapped register
      if (ax_reg.aw_got && ax_reg.w_got)
      begin
         ax_next.aw_got = 1'b0;
         ax_next.w_got  = 1'b0;
         ax_next.bvalid = 1'b1;
         ax_next.bresp  = 2'b00;
         if (ax_reg.aw_addr == `RCS_POWER_CONTROL_FLAGS_ADDR)
         begin
            ax_next.wr = ax_reg.w_strb0;
         end
         else if (ax_reg.aw_addr != `RCS_STAT_ADDR)
         begin
            ax_next.bresp = 2'b10;
         end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         ax_next.bvalid = 1'b0;
      end
      // Reads answer one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready)
      begin
         ax_next.rvalid = 1'b1;
         ax_next.rresp  = 2'b00;
         ax_next.rdata  = 32'h0000_0000;
         if (s_axi_araddr == `RCS_POWER_CONTROL_FLAGS_ADDR)
         begin
            ax_next.rdata = {24'h00_0000, power_control_flags_rd};
         end
         else if (s_axi_araddr == `RCS_STAT_ADDR)
         begin
            ax_next.rdata = {24'h00_0000, stat_rd};
         end
         else
         begin
            ax_next.rresp = 2'b10;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         ax_next.rvalid = 1'b0;
      end
   end

   // Register the slave state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ax_reg <= '0;
      end
      else
      begin
         ax_reg <= ax_next;
      end
   end

   // Ready only while the matching half is not yet held
   assign s_axi_awready = !ax_reg.aw_got && !ax_reg.bvalid;
   assign s_axi_wready  = !ax_reg.w_got && !ax_reg.bvalid;
   assign s_axi_arready = !ax_reg.rvalid;
   assign s_axi_bvalid  = ax_reg.bvalid;
   assign s_axi_bresp   = ax_reg.bresp;
   assign s_axi_rvalid  = ax_reg.rvalid;
   assign s_axi_rdata   = ax_reg.rdata;
   assign s_axi_rresp   = ax_reg.rresp;
   assign power_control_flags_wr       = ax_reg.wr;
   assign power_control_flags_wdata    = ax_reg.w_data;

endmodule

// file: rcs_top_monitor.sv
// Port-level checker of the reset cause block, bound to its top
module rcs_top_monitor
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        external_clear_n,
   input wire logic        watchdog_expire,
   input wire logic        watchdog_clear_instr,
   input wire logic        sleep_enter,
   input wire logic        core_run,
   input wire logic        watchdog_counter_clear,
   input wire logic        asleep,
   input wire logic        ultra_low_wake_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   // -------------------------------------------------------------
   // Properties, all in the one clock domain
   // -------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Pin low long enough to get through the two-flop synchroniser
   sequence s_clr_low;
      !external_clear_n [*4];
   endsequence
   a_wdclr_pulse: assert property (
      watchdog_clear_instr |=> watchdog_counter_clear)
      else $error("counter clear pulse missing");
   a_wdclr_cause: assert property (
      watchdog_counter_clear |-> $past(watchdog_clear_instr))
      else $error("counter clear without instruction");
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rd_single: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   a_clear_stop: assert property (
      s_clr_low |-> !core_run)
      else $error("core runs with clear pin low");
   a_wdt_drop: assert property (
      watchdog_expire && core_run |=> !core_run)
      else $error("watchdog reset did not stop core");
   a_wdt_ulpw: assert property (
      watchdog_expire && core_run |=> !ultra_low_wake_enable)
      else $error("wake enable kept on watchdog reset");
   a_sleep_enter: assert property (
      sleep_enter && core_run && !watchdog_expire |=> asleep)
      else $error("sleep request ignored");
endmodule

bind rcs_top rcs_top_monitor u_mon (.*);

// file: rcs_top_tb.sv
// Self-checking bench of the reset cause block over its register bus
`include "rcs_params.svh"
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch at %0t: %h vs %h", $time, g, e); end end

module rcs_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_run;
   logic        external_clear_n, brownout_detect, powerup_timer_enable_n;
   logic        crystal_osc_modes, watchdog_counter_clear, asleep;
   logic        ultra_low_wake_enable, soft_brownout_enable;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, ev;
   logic [1:0]  s_axi_bresp, s_axi_rresp, brownout_enable_cfg;
   wire logic   watchdog_expire = ev[0];
   wire logic   watchdog_clear_instr = ev[1];
   wire logic   sleep_enter = ev[2];
   wire logic   wake_reset_event = ev[3];
   int          num_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;

   // Short start-up counts keep the run brief
   rcs_top #(.POWERUP_TIMER_CYCLES(20), .OST_CYCLES(8)) DUT (.*);

   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   task report_and_stop();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One register access; sampling at the falling edge avoids races
   task xfer(logic w, logic [11:0] a, logic [7:0] d, logic [1:0] r);
      logic ta, tw, tr, v;
      logic [31:0] dv;
      logic [1:0] rs;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      do
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         v = w ? s_axi_bvalid : s_axi_rvalid;
         rs = w ? s_axi_bresp : s_axi_rresp;
         dv = s_axi_rdata;
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         if (tr)
            s_axi_arvalid <= 1'b0;
      end
      while (!v);
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      `CK(rs, r)
      if (!w)
         `CK(dv, {24'h000000, d})
   endtask

   // Single-cycle event pulse on one of the event inputs
   task hit(int k);
      @(posedge aclk);
      ev <= 4'(4'h1 << k);
      @(posedge aclk);
      ev <= 4'h0;
   endtask

   // Start-up has a bounded length with the shortened counts
   task wait_run();
      int i;
      i = 0;
      repeat (3) @(posedge aclk);
      while (core_run !== 1'b1 && i < 300)
      begin
         @(negedge aclk);
         i++;
      end
      `CK(core_run, 1'b1)
   endtask

   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, brownout_detect, ev} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      {external_clear_n, crystal_osc_modes, powerup_timer_enable_n} = 3'h6;
      brownout_enable_cfg = 2'b01;
      s_axi_wstrb = 4'h1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      wait_run();
      xfer(0, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h18, 2'b00);
      xfer(0, `RCS_STAT_ADDR, 8'h18, 2'b00);
      xfer(1, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h3b, 2'b00);
      xfer(0, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h3b, 2'b00);
      xfer(1, `RCS_STAT_ADDR, 8'h00, 2'b00);
      xfer(0, `RCS_STAT_ADDR, 8'h18, 2'b00);
      xfer(0, 12'h000, 8'h00, 2'b10);
      hit(0);
      wait_run();
      xfer(0, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h1b, 2'b00);
      xfer(0, `RCS_STAT_ADDR, 8'h08, 2'b00);
      hit(1);
      xfer(0, `RCS_STAT_ADDR, 8'h18, 2'b00);
      xfer(1, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h3b, 2'b00);
      external_clear_n <= 1'b0;
      repeat (6) @(posedge aclk);
      external_clear_n <= 1'b1;
      wait_run();
      xfer(0, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h1b, 2'b00);
      xfer(0, `RCS_STAT_ADDR, 8'h18, 2'b00);
      brownout_detect <= 1'b1;
      repeat (4) @(posedge aclk);
      brownout_detect <= 1'b0;
      wait_run();
      xfer(0, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h1a, 2'b00);
      xfer(0, `RCS_STAT_ADDR, 8'h18, 2'b00);
      hit(2);
      @(negedge aclk);
      `CK(asleep, 1'b1)
      hit(3);
      wait_run();
      xfer(0, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h12, 2'b00);
      xfer(0, `RCS_STAT_ADDR, 8'h10, 2'b00);
      // Disabled brown-out circuit: no restart, flags left alone
      brownout_enable_cfg <= 2'b00;
      brownout_detect <= 1'b1;
      repeat (6) @(posedge aclk);
      `CK(core_run, 1'b1)
      brownout_detect <= 1'b0;
      xfer(0, `RCS_POWER_CONTROL_FLAGS_ADDR, 8'h12, 2'b00);
      `CK(soft_brownout_enable, 1'b1)
      `CK(ultra_low_wake_enable, 1'b0)
      report_and_stop();
   end
endmodule
